// ### design/kad_decoder.sv
// chip-select decoder and i/o latches of the digital kernel
// Notes on behaviour
// - ROM select is low for every address 2000..FFFF, from the top 3 bits.
// - nvram select needs ROM select and reset high and a bit of 9..12 high.
// - i/o select low when ROM select high, bits 9..12 low (0000-01FF).
// - counter, digital, option, card selects from i/o select and bits 3..8; card also uses bits 0..2.
// - rtc 1FF8-F nvram 0200-1FF7 cnt 0038-F opt 0028-F page 5-6 data 4.
// - 0032 reads input latch, writes output latch; 0035 is write-only alarm.
// - a RAM power-fail forces reset so the NVRAM select cannot occur.
// - all devices sit on an 8-bit data bus with 16-bit addresses.
// - converter link is asynchronous at 4800 baud on separate lines.
// - both converter link lines rest low when no transfer is in progress.
module kad_decoder #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
) (
    input  wire logic              REF_CLK_I,
    input  wire logic              RESETN_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic              RD_N_I,
    input  wire logic              WR_N_I,
    input  wire logic [DATA_W-1:0] DATA_I,
    output logic      [DATA_W-1:0] DATA_O,
    output logic                   DATA_OE_N_O,
    input  wire logic              SYS_RESET_N_I,
    input  wire logic              POWER_FAIL_N_I,
    output logic                   RESET_REQ_N_O,
    output logic                   ROM_SEL_N_O,
    output logic                   RAM_SEL_N_O,
    output logic                   IO_SEL_N_O,
    output logic                   COUNTER_TIMER_SELECT_N_O,
    output logic                   DIGITAL_LATCH_SELECT_N_O,
    output logic                   BUS_OPTION_SEL_N_O,
    output logic                   MEM_CARD_SEL_N_O,
    input  wire logic [DATA_W-1:0] DIG_IN_I,
    output logic      [DATA_W-1:0] DIG_OUT_O,
    output logic      [DATA_W-1:0] ALARM_O,
    output logic      [15:0]       PAGE_O,
    input  wire logic              CPU_TX_I,
    output logic                   LINK_TX_O,
    input  wire logic              LINK_RX_I,
    output logic                   CPU_RX_O
);
    // ************************************************************
    // elaboration check
    // ************************************************************
    // the decode is hard-wired to a 16-bit address, 8-bit data bus
    if (ADDR_W != 16 || DATA_W != 8) begin : g_bad_width
        $error("kad_decoder needs ADDR_W 16 and DATA_W 8");
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [15:0]       addr_m, addr_s;
    logic              rd_m, rd_s, wr_m, wr_s, wr_d;
    logic [DATA_W-1:0] data_m, data_s, din_m, din_s;
    logic              srst_m, srst_s, pf_m, pf_s;
    logic              tx_m, tx_s, rx_m, rx_s;

    // two flops per pin, plus wr_d as a third on the write strobe; logic never reads a first stage
    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            addr_m <= 16'h0000;
            addr_s <= 16'h0000;
            rd_m   <= 1'b1;
            rd_s   <= 1'b1;
            wr_m   <= 1'b1;
            wr_s   <= 1'b1;
            wr_d   <= 1'b1;
            data_m <= 8'h00;
            data_s <= 8'h00;
            din_m  <= 8'h00;
            din_s  <= 8'h00;
            srst_m <= 1'b0;
            srst_s <= 1'b0;
            pf_m   <= 1'b0;
            pf_s   <= 1'b0;
            tx_m   <= 1'b0;
            tx_s   <= 1'b0;
            rx_m   <= 1'b0;
            rx_s   <= 1'b0;
        end else begin
            addr_m <= ADDR_I;
            addr_s <= addr_m;
            rd_m   <= RD_N_I;
            rd_s   <= rd_m;
            wr_m   <= WR_N_I;
            wr_s   <= wr_m;
            wr_d   <= wr_s;
            data_m <= DATA_I;
            data_s <= data_m;
            din_m  <= DIG_IN_I;
            din_s  <= din_m;
            srst_m <= SYS_RESET_N_I;
            srst_s <= srst_m;
            pf_m   <= POWER_FAIL_N_I;
            pf_s   <= pf_m;
            tx_m   <= CPU_TX_I;
            tx_s   <= tx_m;
            rx_m   <= LINK_RX_I;
            rx_s   <= rx_m;
        end
    end

    // ************************************************************
    // decode
    // ************************************************************
    // active-high selects: {rom, ram, io, counter, digital, busopt, mem}
    function automatic logic [6:0] kad_decode(input logic [15:0] a,
                                              input logic        rst_ok);
        logic       rom;
        logic       io;
        logic [5:0] grp;
        rom = |a[15:13];
        io  = !rom && (a[12:9] == 4'h0);
        grp = a[kad_pkg::GRP_MSB:kad_pkg::GRP_LSB];
        kad_decode[6] = rom;
        kad_decode[5] = !rom && rst_ok && (|a[12:9]);
        kad_decode[4] = io;
        kad_decode[3] = io && grp == kad_pkg::GRP_COUNTER;
        kad_decode[2] = io && grp == kad_pkg::GRP_DIGITAL;
        kad_decode[1] = io && grp == kad_pkg::GRP_BUSOPT;
        // memory card only at data and page bytes; 0000-0003 stays silent
        kad_decode[0] = io && grp == kad_pkg::GRP_MEMCARD
                        && a >= kad_pkg::MEM_DATA_ADDR
                        && a <= kad_pkg::PAGE_HI_ADDR;
    endfunction : kad_decode

    logic       rst_ok;
    logic [6:0] sel;
    logic       wr_end;
    logic       io_hit;

    // a low power-fail line counts as reset, so NVRAM cannot be selected
    assign rst_ok = srst_s && pf_s;
    assign sel    = kad_decode(addr_s, rst_ok);
    // latches load at the strobe's end, when data is surely valid
    assign wr_end = wr_s && !wr_d;
    assign io_hit = sel[4];

    // selects are registered so every output leaves a flip-flop
    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ROM_SEL_N_O              <= 1'b1;
            RAM_SEL_N_O              <= 1'b1;
            IO_SEL_N_O               <= 1'b1;
            COUNTER_TIMER_SELECT_N_O <= 1'b1;
            DIGITAL_LATCH_SELECT_N_O <= 1'b1;
            BUS_OPTION_SEL_N_O       <= 1'b1;
            MEM_CARD_SEL_N_O         <= 1'b1;
            RESET_REQ_N_O            <= 1'b0;
        end else begin
            ROM_SEL_N_O              <= !sel[6];
            RAM_SEL_N_O              <= !sel[5];
            IO_SEL_N_O               <= !sel[4];
            COUNTER_TIMER_SELECT_N_O <= !sel[3];
            DIGITAL_LATCH_SELECT_N_O <= !sel[2];
            BUS_OPTION_SEL_N_O       <= !sel[1];
            MEM_CARD_SEL_N_O         <= !sel[0];
            RESET_REQ_N_O            <= pf_s;
        end
    end

    // ************************************************************
    // write-only latches
    // ************************************************************
    // output, alarm and page latches; page is low byte then high byte
    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            DIG_OUT_O <= kad_pkg::LATCH_RESET;
            ALARM_O   <= kad_pkg::LATCH_RESET;
            PAGE_O    <= kad_pkg::PAGE_RESET;
        end else if (wr_end && io_hit) begin
            if (addr_s == kad_pkg::DIG_LATCH_ADDR) begin
                DIG_OUT_O <= data_s;
            end
            if (addr_s == kad_pkg::ALARM_ADDR) begin
                ALARM_O <= data_s;
            end
            if (addr_s == kad_pkg::PAGE_LO_ADDR) begin
                PAGE_O[7:0] <= data_s;
            end
            if (addr_s == kad_pkg::PAGE_HI_ADDR) begin
                PAGE_O[15:8] <= data_s;
            end
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    // only the input latch is read here; enable is low while driving
    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            DATA_O      <= 8'h00;
            DATA_OE_N_O <= 1'b1;
        end else begin
            DATA_O      <= din_s;
            DATA_OE_N_O <= !(!rd_s && io_hit
                             && addr_s == kad_pkg::DIG_LATCH_ADDR);
        end
    end

    // ************************************************************
    // converter link relay
    // ************************************************************
    // lines pass through at bit level; 4800 baud framing is end to end
    always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            LINK_TX_O <= 1'b0;
            CPU_RX_O  <= 1'b0;
        end else begin
            LINK_TX_O <= tx_s;
            CPU_RX_O  <= rx_s;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    property p_rom;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (addr_s >= kad_pkg::ROM_BASE) |=> !ROM_SEL_N_O;
    endproperty
    a_rom: assert property (p_rom)
        else $error("rom select missing in rom range");

    property p_ram;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        !RAM_SEL_N_O |-> $past(srst_s && pf_s && addr_s < kad_pkg::ROM_BASE
                               && addr_s > kad_pkg::IO_TOP);
    endproperty
    a_ram: assert property (p_ram)
        else $error("nvram select outside its window or in reset");

    property p_io;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (addr_s <= kad_pkg::IO_TOP) |=> !IO_SEL_N_O && ROM_SEL_N_O;
    endproperty
    a_io: assert property (p_io)
        else $error("i/o group select wrong for 0000-01ff");

    property p_sub;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        !(COUNTER_TIMER_SELECT_N_O && DIGITAL_LATCH_SELECT_N_O
          && BUS_OPTION_SEL_N_O && MEM_CARD_SEL_N_O) |-> !IO_SEL_N_O;
    endproperty
    a_sub: assert property (p_sub)
        else $error("second-level select without i/o group");

    property p_counter;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        !COUNTER_TIMER_SELECT_N_O |-> $past(addr_s) >= 16'h0038
                                      && $past(addr_s) <= 16'h003f;
    endproperty
    a_counter: assert property (p_counter)
        else $error("counter select outside 0038-003f");

    property p_dig_out;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (wr_end && io_hit && addr_s == kad_pkg::DIG_LATCH_ADDR)
        |=> DIG_OUT_O == $past(data_s);
    endproperty
    a_dig_out: assert property (p_dig_out)
        else $error("digital output latch not loaded at 0032");

    property p_alarm;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        $changed(ALARM_O) |-> $past(wr_end && io_hit
                                    && addr_s == kad_pkg::ALARM_ADDR);
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("alarm latch changed without write to 0035");

    property p_pfail;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        !pf_s |=> !RESET_REQ_N_O && RAM_SEL_N_O;
    endproperty
    a_pfail: assert property (p_pfail)
        else $error("power fail did not force reset and block nvram");

    property p_onehot;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        $onehot0({!ROM_SEL_N_O, !RAM_SEL_N_O, !IO_SEL_N_O})
        && $onehot0({!COUNTER_TIMER_SELECT_N_O, !DIGITAL_LATCH_SELECT_N_O,
                     !BUS_OPTION_SEL_N_O, !MEM_CARD_SEL_N_O});
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("more than one chip select low");

    property p_link_idle;
        @(posedge REF_CLK_I) disable iff (!RESETN_I)
        (!tx_s && !rx_s) [*2] |-> !LINK_TX_O && !CPU_RX_O;
    endproperty
    a_link_idle: assert property (p_link_idle)
        else $error("idle converter link not resting low");
endmodule : kad_decoder

// ### design/kad_pkg.sv
// constants for the kernel address decoder: map, groups, resets, timing
package kad_pkg;
    // ************************************************************
    // address map
    // ************************************************************
    localparam logic [15:0] ROM_BASE       = 16'h2000;
    localparam logic [15:0] RTC_BASE       = 16'h1ff8;
    localparam logic [15:0] IO_TOP         = 16'h01ff;
    localparam logic [15:0] INT_RAM_BASE   = 16'h0040;
    localparam logic [15:0] INT_RAM_TOP    = 16'h013f;
    localparam logic [15:0] MEM_DATA_ADDR  = 16'h0004;
    localparam logic [15:0] PAGE_LO_ADDR   = 16'h0005;
    localparam logic [15:0] PAGE_HI_ADDR   = 16'h0006;
    localparam logic [15:0] DIG_LATCH_ADDR = 16'h0032;
    localparam logic [15:0] ALARM_ADDR     = 16'h0035;
    // ************************************************************
    // second-level groups on address bits 8..3
    // ************************************************************
    localparam int          GRP_LSB        = 3;
    localparam int          GRP_MSB        = 8;
    localparam logic [5:0]  GRP_MEMCARD    = 6'h00;
    localparam logic [5:0]  GRP_BUSOPT     = 6'h05;
    localparam logic [5:0]  GRP_DIGITAL    = 6'h06;
    localparam logic [5:0]  GRP_COUNTER    = 6'h07;
    // ************************************************************
    // reset values and processor timing
    // ************************************************************
    localparam logic [7:0]  LATCH_RESET    = 8'h00;
    localparam logic [15:0] PAGE_RESET     = 16'h0000;
    localparam int          CLK_MHZ        = 250;
    localparam int          MEM_CYCLE_NS   = 813;
    localparam int          MEM_CYCLE_CYC  = MEM_CYCLE_NS * CLK_MHZ / 1000;
endpackage : kad_pkg

// ### dv/kad_cpu_model.sv
// processor-side model: drives address, strobes and write data
module kad_cpu_model (
    input  wire logic        clk_i,
    output logic      [15:0] addr_o,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic      [7:0]  data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero, both strobes released
    initial begin
        addr_o = 16'h0000;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        data_o = 8'h00;
    end
    // sixteen address lines, settled before any strobe
    task automatic put_addr(input logic [15:0] a);
        @(negedge clk_i);
        addr_o = a;
    endtask : put_addr
    // strobes come one cycle after the address settles
    task automatic rd_low();
        @(negedge clk_i);
        rd_n_o = 1'b0;
    endtask : rd_low
    task automatic rd_high();
        rd_n_o = 1'b1;
    endtask : rd_high
    // strobe far shorter than a real memory cycle, still >= 4 cycles
    task automatic write(input logic [15:0] a, input logic [7:0] d);
        put_addr(a);
        data_o = d;
        @(negedge clk_i);
        wr_n_o = 1'b0;
        repeat (5) @(negedge clk_i);
        wr_n_o = 1'b1;
        repeat (4) @(negedge clk_i);
        data_o = ~d;  // a released bus must not keep showing the last byte
    endtask : write
endmodule : kad_cpu_model

// ### dv/test_kernel_address_decoder.sv
// self-checking bench for the kernel address decoder
module test_kernel_address_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int kind; logic [15:0] exp;} kad_exp_t;
    logic        clk = 1'b0, resetn = 1'b0, sys_rst_n = 1'b1, pf_n = 1'b1;
    logic        tx = 1'b0, rx = 1'b0, rd_n, wr_n, oe_n, rst_req_n;
    logic        rom_n, ram_n, io_n, cnt_n, dig_n, bus_n, mem_n, ltx, crx;
    logic [15:0] addr, page;
    logic [7:0]  wdata, rdata, dig_in = 8'h00, dig_out, alarm, d;
    int          failures = 0, n_compared = 0;
    kad_exp_t    q[$];
    kad_exp_t    e;
    event        chk;
    string       nm[8] = '{"selects", "reset_req", "dig_out", "alarm",
                           "page", "data_oe_n", "data_o", "link"};
    logic [15:0] tbl[24] = '{16'h0000, 16'h0003, 16'h0004, 16'h0005,
        16'h0006, 16'h0007, 16'h0027, 16'h0028, 16'h002f, 16'h0030,
        16'h0032, 16'h0035, 16'h0037, 16'h0038, 16'h003f, 16'h0040,
        16'h013f, 16'h01ff, 16'h0200, 16'h1ff7, 16'h1ff8, 16'h1fff,
        16'h2000, 16'hffff};
    always #2 clk = ~clk;
    kad_cpu_model cpu (.clk_i(clk), .addr_o(addr), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .data_o(wdata));
    kad_decoder dut (.REF_CLK_I(clk), .RESETN_I(resetn), .ADDR_I(addr),
        .RD_N_I(rd_n), .WR_N_I(wr_n), .DATA_I(wdata), .DATA_O(rdata),
        .DATA_OE_N_O(oe_n), .SYS_RESET_N_I(sys_rst_n),
        .POWER_FAIL_N_I(pf_n), .RESET_REQ_N_O(rst_req_n),
        .ROM_SEL_N_O(rom_n), .RAM_SEL_N_O(ram_n), .IO_SEL_N_O(io_n),
        .COUNTER_TIMER_SELECT_N_O(cnt_n), .DIGITAL_LATCH_SELECT_N_O(dig_n),
        .BUS_OPTION_SEL_N_O(bus_n), .MEM_CARD_SEL_N_O(mem_n),
        .DIG_IN_I(dig_in), .DIG_OUT_O(dig_out), .ALARM_O(alarm),
        .PAGE_O(page), .CPU_TX_I(tx), .LINK_TX_O(ltx), .LINK_RX_I(rx),
        .CPU_RX_O(crx));
    // ************************************************************
    // expectations and the watching process
    // ************************************************************
    function automatic logic [15:0] seen(input int k);
        case (k)
            0: return {9'h0, rom_n, ram_n, io_n, cnt_n, dig_n, bus_n, mem_n};
            1: return {15'h0000, rst_req_n};
            2: return {8'h00, dig_out};
            3: return {8'h00, alarm};
            4: return page;
            5: return {15'h0000, oe_n};
            6: return {8'h00, rdata};
            default: return {14'h0000, ltx, crx};
        endcase
    endfunction : seen
    // selects worked out from the map; ok is reset and supply both good
    function automatic logic [15:0] exp_sel(input logic [15:0] a,
                                            input logic ok);
        logic rom, io;
        rom = (a[15:13] == 3'h0);
        io  = rom && (a[12:9] == 4'h0);
        return {9'h000, rom, !(rom && ok && a[12:9] != 4'h0), !io,
            !(io && a[8:3] == 6'h07), !(io && a[8:3] == 6'h06),
            !(io && a[8:3] == 6'h05),
            !(io && a[8:3] == 6'h00 && a[2:0] >= 3'h4 && a[2:0] <= 3'h6)};
    endfunction : exp_sel
    task automatic note(input int k, input logic [15:0] v);
        q.push_back('{k, v});
        ->chk;
    endtask : note
    // address held 4 cycles covers the 3-edge select lag
    task automatic sel_check(input logic [15:0] a, input logic ok);
        cpu.put_addr(a);
        repeat (4) @(negedge clk);
        note(0, exp_sel(a, ok));
    endtask : sel_check
    task automatic report_and_stop;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    // every queued note is compared, oldest first, whenever a result is announced
    always begin
        @(chk);
        while (q.size() > 0) begin
            e = q.pop_front();
            n_compared++;
            if (seen(e.kind) !== e.exp) begin
                failures++;
                $display("FAIL %s expected %h seen %h", nm[e.kind], e.exp,
                    seen(e.kind));
            end
        end
    end
    // watchdog: the run needs about 400 cycles, the limit allows 10000
    initial begin
        #40000;
        failures++;
        report_and_stop();
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h0154));
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        note(7, 16'h0000);
        note(2, 16'h0000);
        note(4, 16'h0000);
        note(5, 16'h0001);
        foreach (tbl[i]) sel_check(tbl[i], 1'b1);
        repeat (24) sel_check(16'($urandom), 1'b1);
        sys_rst_n = 1'b0;
        sel_check(16'h0200, 1'b0);
        sel_check(16'h1fff, 1'b0);
        sys_rst_n = 1'b1;
        pf_n = 1'b0;
        sel_check(16'h1000, 1'b0);
        note(1, 16'h0000);
        pf_n = 1'b1;
        sel_check(16'h1ff8, 1'b1);
        note(1, 16'h0001);
        d = 8'($urandom);
        cpu.write(16'h0032, d);
        cpu.write(16'h0035, ~d);
        cpu.write(16'h0033, 8'h00);
        note(2, {8'h00, d});
        note(3, {8'h00, ~d});
        cpu.write(16'h0005, d ^ 8'h3c);
        cpu.write(16'h0006, ~d);
        cpu.write(16'h0004, 8'hff);
        note(4, {~d, d ^ 8'h3c});
        dig_in = 8'($urandom);
        cpu.put_addr(16'h0032);
        cpu.rd_low();
        repeat (5) @(negedge clk);
        note(5, 16'h0000);
        note(6, {8'h00, dig_in});
        cpu.rd_high();
        repeat (4) @(negedge clk);
        note(5, 16'h0001);
        cpu.put_addr(16'h0035);
        cpu.rd_low();
        repeat (5) @(negedge clk);
        note(5, 16'h0001);
        cpu.rd_high();
        repeat (8) begin
            tx = 1'($urandom);
            rx = 1'($urandom);
            repeat (4) @(negedge clk);
            note(7, {14'h0000, tx, rx});
        end
        tx = 1'b0;
        rx = 1'b0;
        repeat (4) @(negedge clk);
        note(7, 16'h0000);
        @(negedge clk);
        report_and_stop();
    end
endmodule : test_kernel_address_decoder
